// File: design/line_ctl_cfg.svh
// constants for the line, hold and hands-free control block
// assumes a 10 MHz core clock and one separate display link clock
`ifndef LINE_CTL_CFG_SVH
`define LINE_CTL_CFG_SVH
`define CLK_HZ 10000000
`define PULSE10_MS 100
`define PULSE20_MS 50
`define TONE_MS 100
`define GAP_MS 100
`define MS_CYC(ms) ((ms) * (`CLK_HZ / 1000))
`define BREAK_NUM 2
`define BREAK_DEN 3
`define TONE_HALF_CYC 20'h00007
`define ADDR_DIGIT 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CTRL 8'h08
`define CTRL_RST 1'b1
`define PINS_IDLE 5'h18
`define DIGIT_MAX 4'h9
`endif

// File: design/line_ctl_pkg.sv
// types shared by the line control block and its display link
package line_ctl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_BREAK = 5'h02,
    ST_MAKE = 5'h04,
    ST_TONE = 5'h08,
    ST_GAP = 5'h10
  } dial_st_t;
  typedef enum logic [1:0] {
    MODE_TONE = 2'h0,
    MODE_P10 = 2'h1,
    MODE_P20 = 2'h2
  } dial_mode_t;
  // telephone pins; mode pin sensed by two level comparators
  typedef struct packed {
    logic hookSwitchSense;
    logic holdToggleIn;
    logic handsfreeToggleIn;
    logic modeSenseHigh;
    logic modeSenseLow;
  } pins_t;
  typedef struct packed {
    logic dataOe;
    logic clkOe;
  } disp_pins_t;
endpackage

// File: design/display_link.sv
// display link serializer on the link clock
// assumes the digit stays stable while request and acknowledge differ
`timescale 1ns/1ps
`include "line_ctl_cfg.svh"
module display_link import line_ctl_pkg::*; (
  // clock and core-domain controls
  input wire logic linkClk,
  input wire logic nrst,
  input wire logic ce,
  // handshake from the core
  input wire logic req,
  input wire logic [3:0] digit,
  output logic ack,
  // open-drain pins
  output disp_pins_t disp
);
  typedef struct packed {
    logic [1:0] rstSync;
    logic [1:0] ceSync;
    logic [1:0] reqSync;
    logic reqSeen;
    logic ack;
    logic busy;
    logic phase;
    logic [2:0] bitCnt;
    logic [3:0] shift;
    disp_pins_t disp;
  } link_t;
  link_t s;
  link_t next_s;

  always_comb begin
    next_s = s;
    next_s.rstSync = {s.rstSync[0], nrst};
    next_s.ceSync = {s.ceSync[0], ce};
    next_s.reqSync = {s.reqSync[0], req};
    if (!s.rstSync[1]) begin
      next_s.reqSeen = s.reqSync[1];
      next_s.ack = s.reqSync[1];
      next_s.busy = 1'b0;
      next_s.phase = 1'b0;
      next_s.bitCnt = 3'h0;
      next_s.disp = '0;
    end else if (s.ceSync[1]) begin
      if (!s.busy && s.reqSync[1] != s.reqSeen) begin
        next_s.reqSeen = s.reqSync[1];
        next_s.shift = digit;
        next_s.busy = 1'b1;
        next_s.bitCnt = 3'h4;
        next_s.phase = 1'b0;
      end else if (s.busy) begin
        if (!s.phase) begin
          next_s.disp.dataOe = ~s.shift[3];
          next_s.disp.clkOe = 1'b0;
          next_s.phase = s.bitCnt != 3'h0;
          if (s.bitCnt == 3'h0) begin
            next_s.busy = 1'b0;
            next_s.disp.dataOe = 1'b0;
            next_s.ack = s.reqSeen;
          end
        end else begin
          next_s.disp.clkOe = 1'b1;
          next_s.shift = {s.shift[2:0], 1'b0};
          next_s.bitCnt = s.bitCnt - 3'h1;
          next_s.phase = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge linkClk) begin
    s <= next_s;
  end
  assign ack = s.ack;
  assign disp = s.disp;

  a_data_at_fall: assert property (@(posedge linkClk) disable iff (!s.rstSync[1])
    $rose(s.disp.clkOe) |-> $stable(s.disp.dataOe))
    else $error("display data moved at clock fall");
  c_digit_sent: cover property (@(posedge linkClk) $changed(s.ack));
endmodule

// File: design/line_hold_handsfree_control.sv
// line make/break, hold and hands-free latches, dial sequencer, axi4-lite regs
// assumes pins are asynchronous; display link clock is unrelated to core_clk
`timescale 1ns/1ps
`include "line_ctl_cfg.svh"
module line_hold_handsfree_control import line_ctl_pkg::*; #(
  parameter int pulse10Cyc = `MS_CYC(`PULSE10_MS),
  parameter int pulse20Cyc = `MS_CYC(`PULSE20_MS),
  parameter int toneCyc = `MS_CYC(`TONE_MS),
  parameter int gapCyc = `MS_CYC(`GAP_MS)
) (
  // clocks, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic linkClk,
  // telephone pins
  input wire pins_t pinIn,
  output logic lineControlOut,
  output logic toneOut,
  output logic speechMuteOutOe,
  output logic holdStateOut,
  output logic handsfreeStateOut,
  // display link pins
  output disp_pins_t disp,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  localparam logic [19:0] B10 = 20'(pulse10Cyc * `BREAK_NUM / `BREAK_DEN);
  localparam logic [19:0] M10 = 20'(pulse10Cyc) - B10;
  localparam logic [19:0] B20 = 20'(pulse20Cyc * `BREAK_NUM / `BREAK_DEN);
  localparam logic [19:0] M20 = 20'(pulse20Cyc) - B20;

  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    pins_t prev;
    logic hold;
    logic hf;
    logic line;
    logic tone;
    logic mute;
    dial_st_t st;
    logic [19:0] cnt;
    logic [19:0] toneDiv;
    logic [19:0] makeLen;
    logic [19:0] breakLen;
    logic [3:0] pulses;
    logic [3:0] lastDigit;
    logic dispEn;
    logic dispReq;
    logic [3:0] dispDigit;
    logic [1:0] ackSync;
    logic awHave;
    logic wHave;
    logic [7:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } core_t;

  core_t s;
  core_t next_s;
  logic linkAck;
  dial_mode_t mode;
  logic hookEdge;
  logic holdFall;
  logic hfRise;
  logic dispPending;
  logic busy;
  logic startDigit;

  // ****************************************
  // display link crossing
  // ****************************************
  display_link u_link (
    .linkClk(linkClk),
    .nrst(nrst),
    .ce(ce),
    .req(s.dispReq),
    .digit(s.dispDigit),
    .ack(linkAck),
    .disp(disp)
  );

  // ****************************************
  // pin decode
  // ****************************************
  always_comb begin
    if (s.sync2.modeSenseHigh) begin
      mode = MODE_P10;
    end else if (s.sync2.modeSenseLow) begin
      mode = MODE_TONE;
    end else begin
      mode = MODE_P20;
    end
    hookEdge = s.sync2.hookSwitchSense != s.prev.hookSwitchSense;
    holdFall = s.prev.holdToggleIn && !s.sync2.holdToggleIn;
    hfRise = !s.prev.handsfreeToggleIn && s.sync2.handsfreeToggleIn;
    dispPending = s.dispReq != s.ackSync[1];
    busy = s.st != ST_IDLE;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    startDigit = 1'b0;
    next_s.sync1 = pinIn;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.ackSync = {s.ackSync[0], linkAck};

    if (holdFall) begin
      next_s.hold = !s.hold;
    end
    if (hfRise) begin
      next_s.hf = !s.hf;
    end
    if (next_s.hf && !s.hf) begin
      next_s.hold = 1'b0;
    end else if (next_s.hold && !s.hold) begin
      next_s.hf = 1'b0;
    end
    if (hookEdge) begin
      next_s.hold = 1'b0;
      next_s.hf = 1'b0;
    end

    // ---- axi write ----
    if (awvalid && s.awReady) begin
      next_s.awHave = 1'b1;
      next_s.wAddr = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wHave = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end
    if (s.awHave && s.wHave && !s.bValid) begin
      next_s.awHave = 1'b0;
      next_s.wHave = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = 2'h0;
      case (s.wAddr)
        `ADDR_DIGIT: begin
          // no dialing on-hook; busy or bad digit refused
          if (s.sync2.hookSwitchSense || busy || (s.dispEn && dispPending)
              || s.wData[3:0] > `DIGIT_MAX || !s.wStrb[0]) begin
            next_s.bResp = 2'h2;
          end else begin
            startDigit = 1'b1;
          end
        end
        `ADDR_CTRL: begin
          if (s.wStrb[0]) begin
            next_s.dispEn = s.wData[0];
          end
        end
        `ADDR_STATUS: begin
          next_s.bResp = 2'h0;
        end
        default: begin
          next_s.bResp = 2'h2;
        end
      endcase
    end
    next_s.awReady = !next_s.awHave;
    next_s.wReady = !next_s.wHave;

    // ---- axi read ----
    if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
      next_s.arReady = 1'b1;
    end
    if (arvalid && s.arReady) begin
      next_s.arReady = 1'b0;
      next_s.rValid = 1'b1;
      next_s.rResp = 2'h0;
      case (araddr)
        `ADDR_DIGIT: next_s.rData = {28'h0000000, s.lastDigit};
        `ADDR_STATUS: next_s.rData = {25'h0000000, dispPending, busy, mode, s.hf, s.hold,
                                      s.sync2.hookSwitchSense};
        `ADDR_CTRL: next_s.rData = {31'h00000000, s.dispEn};
        default: begin
          next_s.rData = 32'h00000000;
          next_s.rResp = 2'h2;
        end
      endcase
    end

    // ---- dial sequencer ----
    if (s.cnt != 20'h00000) begin
      next_s.cnt = s.cnt - 20'h00001;
    end
    case (s.st)
      ST_IDLE: begin
        if (startDigit) begin
          next_s.lastDigit = s.wData[3:0];
          next_s.pulses = (s.wData[3:0] == 4'h0) ? 4'ha : s.wData[3:0];
          // hand the digit to the display link
          if (s.dispEn) begin
            next_s.dispReq = !s.dispReq;
            next_s.dispDigit = s.wData[3:0];
          end
          if (mode == MODE_TONE) begin
            next_s.st = ST_TONE;
            next_s.cnt = 20'(toneCyc);
          end else begin
            next_s.st = ST_BREAK;
            next_s.breakLen = (mode == MODE_P10) ? B10 : B20;
            next_s.makeLen = (mode == MODE_P10) ? M10 : M20;
            next_s.cnt = (mode == MODE_P10) ? B10 : B20;
          end
        end
      end
      ST_BREAK: begin
        if (s.cnt == 20'h00000) begin
          next_s.st = ST_MAKE;
          next_s.cnt = s.makeLen;
        end
      end
      ST_MAKE: begin
        if (s.cnt == 20'h00000) begin
          next_s.pulses = s.pulses - 4'h1;
          next_s.st = (s.pulses == 4'h1) ? ST_GAP : ST_BREAK;
          next_s.cnt = (s.pulses == 4'h1) ? 20'(gapCyc) : s.breakLen;
        end
      end
      ST_TONE: begin
        if (s.cnt == 20'h00000) begin
          next_s.st = ST_GAP;
          next_s.cnt = 20'(gapCyc);
        end
      end
      ST_GAP: begin
        if (s.cnt == 20'h00000) begin
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    if (s.sync2.hookSwitchSense) begin
      next_s.st = ST_IDLE;
    end

    // ---- pin outputs ----
    // tone only during tone burst; real synthesis lives elsewhere
    next_s.toneDiv = s.toneDiv + 20'h00001;
    if (s.st == ST_TONE) begin
      if (s.toneDiv >= `TONE_HALF_CYC) begin
        next_s.toneDiv = 20'h00000;
        next_s.tone = !s.tone;
      end
    end else begin
      next_s.tone = 1'b0;
    end
    // make/break from hook and latches; pulse breaks
    next_s.line = (!s.sync2.hookSwitchSense || s.hold || s.hf) && s.st != ST_BREAK;
    next_s.mute = s.st == ST_BREAK || s.st == ST_MAKE || s.st == ST_TONE;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
      s.sync1 <= `PINS_IDLE;
      s.sync2 <= `PINS_IDLE;
      s.prev <= `PINS_IDLE;
      s.st <= ST_IDLE;
      s.dispEn <= `CTRL_RST;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign lineControlOut = s.line;
  assign toneOut = s.tone;
  assign speechMuteOutOe = s.mute;
  assign holdStateOut = s.hold;
  assign handsfreeStateOut = s.hf;
  assign awready = s.awReady;
  assign wready = s.wReady;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arReady;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_line_break: assert property (ce && s.sync2.hookSwitchSense && !s.hold && !s.hf |=> !lineControlOut)
    else $error("line not broken on-hook");
  a_line_make: assert property (ce && (!s.sync2.hookSwitchSense || s.hold || s.hf) && s.st != ST_BREAK
    |=> lineControlOut)
    else $error("line not made");
  a_pulse_break: assert property (ce && s.st == ST_BREAK |=> !lineControlOut)
    else $error("no break during pulse");
  a_onhook_idle: assert property (ce && s.sync2.hookSwitchSense |=> s.st == ST_IDLE)
    else $error("dialing while on-hook");
  a_tone_quiet: assert property (ce && s.st != ST_TONE |=> !toneOut)
    else $error("tone outside tone burst");
  a_mute_dial: assert property (ce && s.st inside {ST_BREAK, ST_MAKE, ST_TONE} |=> speechMuteOutOe)
    else $error("mute released while dialing");
  a_hold_toggle: assert property (ce && holdFall && !hfRise && !hookEdge
    |=> holdStateOut != $past(holdStateOut))
    else $error("hold did not toggle");
  a_hf_toggle: assert property (ce && hfRise && !hookEdge |=> handsfreeStateOut != $past(handsfreeStateOut))
    else $error("hands-free did not toggle");
  a_hook_clears: assert property (ce && hookEdge |=> !holdStateOut && !handsfreeStateOut)
    else $error("hook change kept a latch");
  a_latch_excl: assert property (!(holdStateOut && handsfreeStateOut))
    else $error("hold and hands-free both set");
  a_mode_tone: assert property (ce && startDigit && mode == MODE_TONE |=> s.st == ST_TONE)
    else $error("tone mode not decoded");
  a_mode_kept: assert property (ce && !s.sync2.hookSwitchSense && s.st == ST_MAKE && s.cnt == 20'h00000
    && s.pulses != 4'h1 |=> s.st == ST_BREAK && s.cnt == $past(s.breakLen))
    else $error("pulse timing changed mid digit");

  c_pulse_digit: cover property (s.st == ST_BREAK ##1 s.st == ST_MAKE);
  c_tone_digit: cover property (s.st == ST_TONE);
  c_hold_onhook: cover property (s.sync2.hookSwitchSense && holdStateOut && lineControlOut);
endmodule

// File: verif/display_rx.sv
// receiver model for the dialed-digit display link
// assumes pulled-up open-drain pins; an enable high pulls its pin low
`timescale 1ns/1ps
module display_rx import line_ctl_pkg::*; (
  // open-drain pins as driven by the dialer
  input wire disp_pins_t disp,
  // received digits
  output logic [3:0] lastDigit,
  output int frames
);
  logic [3:0] shiftReg = 4'h0;
  int bitCount = 0;
  initial begin
    lastDigit = 4'h0;
    frames = 0;
  end
  // sample data at clock pin fall, msb first
  always @(posedge disp.clkOe) begin
    shiftReg = {shiftReg[2:0], ~disp.dataOe};
    bitCount = bitCount + 1;
    if (bitCount == 4) begin
      lastDigit = shiftReg;
      frames = frames + 1;
      bitCount = 0;
    end
  end
endmodule

// File: verif/line_hold_handsfree_control_tb.sv
// self-checking bench for the line, hold and hands-free control block
// assumes short dial timing parameters and a display receiver model
`timescale 1ns/1ps
module line_hold_handsfree_control_tb import line_ctl_pkg::*;;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  pins_t pinIn = 5'h19;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic lineControlOut, toneOut, speechMuteOutOe, holdStateOut, handsfreeStateOut;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  disp_pins_t disp;
  logic [3:0] rxDigit;
  int rxFrames, m;
  int failCount = 0, checks = 0, lineFalls = 0, toneEdges = 0, muteCyc = 0;
  logic prevLine = 1'b0, prevTone = 1'b0;

  always #50 core_clk = ~core_clk;
  // 6 ns link clock; 100 ns is no multiple of it, so the phases drift
  always #3 linkClk = ~linkClk;

  line_hold_handsfree_control #(.pulse10Cyc(30), .pulse20Cyc(15), .toneCyc(20), .gapCyc(10)) uut (
    .core_clk(core_clk), .nrst(nrst), .ce(1'b1), .linkClk(linkClk), .pinIn(pinIn),
    .lineControlOut(lineControlOut), .toneOut(toneOut), .speechMuteOutOe(speechMuteOutOe),
    .holdStateOut(holdStateOut), .handsfreeStateOut(handsfreeStateOut), .disp(disp),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  display_rx rx (.disp(disp), .lastDigit(rxDigit), .frames(rxFrames));

  // line breaks, tone toggles and muted cycles seen at the pins
  always @(posedge core_clk) begin
    prevLine <= lineControlOut;
    prevTone <= toneOut;
    if (prevLine === 1'b1 && lineControlOut === 1'b0) lineFalls <= lineFalls + 1;
    if (prevTone !== toneOut) toneEdges <= toneEdges + 1;
    if (speechMuteOutOe === 1'b1) muteCyc <= muteCyc + 1;
  end

  // ********
  // tasks
  // ********
  task printVerdict;
    $display("mismatches %0d checks %0d", failCount, checks);
    if (failCount == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task hang(input string what);
    failCount++;
    $display("[FAIL] %0t no answer: %s", $time, what);
    printVerdict();
  endtask

  task waitCyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task axiWr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 100) hang("write");
    resp = bresp;
    bready <= 1'b0;
  endtask

  task axiRd(input logic [7:0] a);
    int i;
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 100) hang("read");
    resp = rresp;
    rd = rdata;
    rready <= 1'b0;
  endtask

  // one press of the hold (1) or hands-free (0) button
  task tgl(input logic hold);
    @(posedge core_clk);
    if (hold) pinIn.holdToggleIn <= 1'b0;
    else pinIn.handsfreeToggleIn <= 1'b1;
    waitCyc(6);
    pinIn.holdToggleIn <= 1'b1;
    pinIn.handsfreeToggleIn <= 1'b0;
    waitCyc(6);
  endtask

  task hook(input logic onHook);
    @(posedge core_clk);
    pinIn.hookSwitchSense <= onHook;
    waitCyc(6);
  endtask

  task setMode(input int md);
    @(posedge core_clk);
    pinIn.modeSenseHigh <= (md == 1);
    pinIn.modeSenseLow <= (md == 0);
  endtask

  task latches(input logic h, input logic f, input logic line, input string what);
    chk(holdStateOut, h, what);
    chk(handsfreeStateOut, f, what);
    chk(lineControlOut, line, what);
  endtask

  task waitIdle;
    int i;
    for (i = 0; i < 500; i++) begin
      axiRd(8'h04);
      if (rd[6:5] === 2'b00) break;
    end
    if (i == 500) hang("idle");
  endtask

  // dial one digit; mode may be changed right after it is taken
  task dial(input logic [3:0] d, input int falls, input logic tone, input int modeAfter);
    int f0, t0, m0, r0;
    f0 = lineFalls;
    t0 = toneEdges;
    m0 = muteCyc;
    r0 = rxFrames;
    axiWr(8'h00, {28'h0, d});
    chk(resp, 2'h0, "dial resp");
    if (modeAfter >= 0) setMode(modeAfter);
    waitIdle();
    waitCyc(2);
    chk(lineFalls - f0, falls, "pulses");
    chk(toneEdges != t0, tone, "tone");
    chk(muteCyc > m0, 1'b1, "mute");
    chk({speechMuteOutOe, toneOut, lineControlOut}, 3'b001, "idle pins");
    chk(rxFrames - r0, 1, "frames");
    chk(rxDigit, d, "display digit");
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    waitCyc(10);
    nrst <= 1'b1;
    waitCyc(4);
    chk({lineControlOut, toneOut, speechMuteOutOe, holdStateOut, handsfreeStateOut}, 5'h00, "reset");
    axiRd(8'h08);
    chk(rd, 32'h1, "ctrl reset");
    axiRd(8'h04);
    chk(rd, 32'h1, "status reset");
    axiWr(8'h00, 32'h3);
    chk(resp, 2'h2, "on-hook dial");
    tgl(1'b1);
    latches(1'b1, 1'b0, 1'b1, "hold on");
    tgl(1'b1);
    latches(1'b0, 1'b0, 1'b0, "hold off");
    tgl(1'b0);
    latches(1'b0, 1'b1, 1'b1, "hf on");
    tgl(1'b1);
    latches(1'b1, 1'b0, 1'b1, "hold clears hf");
    tgl(1'b0);
    latches(1'b0, 1'b1, 1'b1, "hf clears hold");
    tgl(1'b0);
    latches(1'b0, 1'b0, 1'b0, "hf off");
    tgl(1'b1);
    hook(1'b0);
    latches(1'b0, 1'b0, 1'b1, "off-hook clears hold");
    tgl(1'b0);
    hook(1'b1);
    latches(1'b0, 1'b0, 1'b0, "on-hook clears hf");
    hook(1'b0);
    for (m = 0; m < 3; m++) begin
      setMode(m);
      waitCyc(6);
      axiRd(8'h04);
      chk(rd[4:3], m, "mode");
    end
    setMode(0);
    waitCyc(6);
    dial(4'h5, 0, 1'b1, 1);
    dial(4'h3, 3, 1'b0, 2);
    dial(4'h0, 10, 1'b0, -1);
    axiWr(8'h00, 32'ha);
    chk(resp, 2'h2, "digit ten");
    axiWr(8'h0c, 32'h1);
    chk(resp, 2'h2, "unmapped write");
    axiRd(8'h10);
    chk(resp, 2'h2, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    axiWr(8'h00, 32'h1);
    axiWr(8'h00, 32'h2);
    chk(resp, 2'h2, "busy dial");
    waitIdle();
    chk(rxDigit, 4'h1, "busy kept digit");
    // a digit write without its low byte strobe is refused
    wstrb <= 4'he;
    axiWr(8'h00, 32'h4);
    chk(resp, 2'h2, "no strobe");
    wstrb <= 4'hf;
    // display off: the digit dials but no frame leaves
    axiWr(8'h08, 32'h0);
    chk(resp, 2'h0, "ctrl write");
    axiRd(8'h08);
    chk(rd, 32'h0, "ctrl readback");
    m = rxFrames;
    axiWr(8'h00, 32'h2);
    chk(resp, 2'h0, "dial no display");
    waitIdle();
    chk(rxFrames - m, 0, "display off");
    axiRd(8'h00);
    chk(rd, 32'h2, "last digit");
    printVerdict();
  end
endmodule
